// ==== ams_consts.svh ====
`ifndef AMS_CONSTS_SVH
`define AMS_CONSTS_SVH

// Register byte offsets
`define AMS_OFF_CTRL 8'h00
`define AMS_OFF_ADDR 8'h04
`define AMS_OFF_WDATA 8'h08
`define AMS_OFF_RDATA 8'h0C
`define AMS_OFF_CFG 8'h10
`define AMS_OFF_STATUS 8'h14

// Region configuration fields, most significant first
`define AMS_SS_BIT 31
`define AMS_EW_BIT 30
`define AMS_WSU_HI 29
`define AMS_WSU_LO 26
`define AMS_WST_HI 25
`define AMS_WST_LO 20
`define AMS_WHD_HI 19
`define AMS_WHD_LO 17
`define AMS_RSU_HI 16
`define AMS_RSU_LO 13
`define AMS_RST_HI 12
`define AMS_RST_LO 7
`define AMS_RHD_HI 6
`define AMS_RHD_LO 4
`define AMS_TA_HI 3
`define AMS_TA_LO 2
`define AMS_ASZ_HI 1
`define AMS_ASZ_LO 0
`define AMS_CFG_RESET 32'h3FFFFFFD
`define AMS_ASZ_16 2'h1

// Control and status bits
`define AMS_CTRL_START 0
`define AMS_CTRL_WRITE 1
`define AMS_STAT_BUSY 0
`define AMS_STAT_DONE 1

`define AMS_ADDR_W 23
`define AMS_DATA_W 16
`define AMS_CNT_W 6
`define AMS_PC_W 8

`endif

// ==== ams_pkg.sv ====
package ams_pkg;

   typedef enum logic [2:0] {
      AMS_IDLE = 3'h0,
      AMS_SETUP = 3'h1,
      AMS_STROBE = 3'h2,
      AMS_HOLD = 3'h3,
      AMS_TURN = 3'h4
   } ams_state_t;

   typedef struct packed {
      logic [31:0] cfg;
      logic [22:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic wr;
      logic busy;
      logic done;
      ams_state_t st;
      logic [5:0] cnt;
      logic ack;
      logic [31:0] dat;
      logic cs_n;
      logic we_n;
      logic oe_n;
      logic [15:0] dq;
      logic dq_oe;
   } ams_regs_t;

endpackage

// ==== ams_ctrl.sv ====
// Operation
// - Select strobe mode strobes with chip select
// - Width field one selects 16-bit data
// - Read strobe lasts count plus one
// - Read hold lasts count plus one
// - No drive until hold plus turnaround plus two
// - Turnaround field two bits, maximum three
// - Write strobe lasts count plus one
// - Write gap is hold plus setup plus two
// - Write access lasts sum plus three
// - Configuration register at 0x10, documented layout
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ams_consts.svh"

module ams_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [22:0] mem_addr_o,
   output logic mem_cs_n_o,
   output logic mem_we_n_o,
   output logic mem_oe_n_o,
   output logic [15:0] mem_data_o,
   output logic mem_data_oe_o,
   input wire logic [15:0] mem_data_i
);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic is16(input logic [31:0] cfg);
      return cfg[`AMS_ASZ_HI:`AMS_ASZ_LO] == `AMS_ASZ_16;
   endfunction

   ams_pkg::ams_regs_t r, n;
   logic wb_req;
   logic wb_wr;
   logic [31:0] cfg_m;
   logic [31:0] addr_m;
   logic [31:0] wdat_m;

   assign wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
   assign wb_wr = wb_req & wb_we_i;

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      n.ack = wb_req;
      cfg_m = merge(r.cfg, wb_dat_i, wb_sel_i);
      addr_m = merge({9'h000, r.addr}, wb_dat_i, wb_sel_i);
      wdat_m = merge({16'h0000, r.wdata}, wb_dat_i, wb_sel_i);
      // Reads return the register image; unmapped offsets read zero
      n.dat = 32'h0;
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            `AMS_OFF_ADDR: n.dat = {9'h000, r.addr};
            `AMS_OFF_WDATA: n.dat = {16'h0000, r.wdata};
            `AMS_OFF_RDATA: n.dat = {16'h0000, r.rdata};
            `AMS_OFF_CFG: n.dat = r.cfg;
            `AMS_OFF_STATUS: n.dat = {30'h0, r.done, r.busy};
            default: n.dat = 32'h0;
         endcase
      end
      // Writes that would disturb a running access are dropped
      if (wb_wr && !r.busy) begin
         unique case (wb_adr_i)
            `AMS_OFF_ADDR: n.addr = addr_m[`AMS_ADDR_W-1:0];
            `AMS_OFF_WDATA: n.wdata = wdat_m[`AMS_DATA_W-1:0];
            `AMS_OFF_CFG: n.cfg = cfg_m;
            default: ;
         endcase
      end
      if (wb_wr && wb_adr_i == `AMS_OFF_STATUS && wb_sel_i[0] && wb_dat_i[`AMS_STAT_DONE]) begin
         n.done = 1'b0;
      end
      if (wb_wr && wb_adr_i == `AMS_OFF_CTRL && wb_sel_i[0] && !r.busy
          && wb_dat_i[`AMS_CTRL_START]) begin
         n.busy = 1'b1;
         n.done = 1'b0;
         n.wr = wb_dat_i[`AMS_CTRL_WRITE];
         n.st = ams_pkg::AMS_SETUP;
         n.cnt = wb_dat_i[`AMS_CTRL_WRITE] ? 6'(r.cfg[`AMS_WSU_HI:`AMS_WSU_LO])
                                           : 6'(r.cfg[`AMS_RSU_HI:`AMS_RSU_LO]);
      end

      // Phase sequencer: each phase runs its count plus one cycles
      unique case (r.st)
         ams_pkg::AMS_IDLE: ;
         ams_pkg::AMS_SETUP: begin
            if (r.cnt != 6'h00) begin
               n.cnt = r.cnt - 6'h01;
            end else begin
               n.st = ams_pkg::AMS_STROBE;
               n.cnt = r.wr ? r.cfg[`AMS_WST_HI:`AMS_WST_LO] : r.cfg[`AMS_RST_HI:`AMS_RST_LO];
            end
         end
         ams_pkg::AMS_STROBE: begin
            if (r.cnt != 6'h00) begin
               n.cnt = r.cnt - 6'h01;
            end else begin
               n.st = ams_pkg::AMS_HOLD;
               n.cnt = r.wr ? 6'(r.cfg[`AMS_WHD_HI:`AMS_WHD_LO])
                            : 6'(r.cfg[`AMS_RHD_HI:`AMS_RHD_LO]);
               // upper byte only on wide bus
               if (!r.wr) begin
                  n.rdata = is16(r.cfg) ? mem_data_i : {8'h00, mem_data_i[7:0]};
               end
            end
         end
         ams_pkg::AMS_HOLD: begin
            if (r.cnt != 6'h00) begin
               n.cnt = r.cnt - 6'h01;
            end else if (r.wr) begin
               n.st = ams_pkg::AMS_IDLE;
               n.busy = 1'b0;
               n.done = 1'b1;
            end else begin
               n.st = ams_pkg::AMS_TURN;
               n.cnt = 6'(r.cfg[`AMS_TA_HI:`AMS_TA_LO]);
            end
         end
         ams_pkg::AMS_TURN: begin
            if (r.cnt != 6'h00) begin
               n.cnt = r.cnt - 6'h01;
            end else begin
               n.st = ams_pkg::AMS_IDLE;
               n.busy = 1'b0;
               n.done = 1'b1;
            end
         end
         default: begin
            n.st = ams_pkg::AMS_IDLE;
            n.busy = 1'b0;
         end
      endcase

      // Pins follow the next phase so they leave straight from flops
      // select strobe mode
      if (n.cfg[`AMS_SS_BIT]) begin
         n.cs_n = n.st != ams_pkg::AMS_STROBE;
         n.we_n = !(n.wr && n.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE,
                                         ams_pkg::AMS_HOLD});
         n.oe_n = !(!n.wr && n.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE,
                                          ams_pkg::AMS_HOLD});
      end else begin
         n.cs_n = !(n.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE, ams_pkg::AMS_HOLD});
         n.we_n = !(n.wr && n.st == ams_pkg::AMS_STROBE);
         n.oe_n = !(!n.wr && n.st == ams_pkg::AMS_STROBE);
      end
      // write data driven through setup, strobe and hold
      n.dq_oe = n.wr && n.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE,
                                     ams_pkg::AMS_HOLD};
      // narrow bus leaves the upper lane zero
      n.dq = is16(n.cfg) ? n.wdata : {8'h00, n.wdata[7:0]};
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '{cfg: `AMS_CFG_RESET, st: ams_pkg::AMS_IDLE, cs_n: 1'b1, we_n: 1'b1,
                oe_n: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign mem_addr_o = r.addr;
   assign mem_cs_n_o = r.cs_n;
   assign mem_we_n_o = r.we_n;
   assign mem_oe_n_o = r.oe_n;
   assign mem_data_o = r.dq;
   assign mem_data_oe_o = r.dq_oe;

   // ==========================================================
   // Checks
   logic [7:0] pc_reg;
   logic [7:0] acc_reg;
   logic [7:0] gap_reg;
   logic [5:0] exp_rst, exp_rhd, exp_wst;
   logic [7:0] exp_sum;
   logic [1:0] exp_ta;

   assign exp_rst = r.cfg[`AMS_RST_HI:`AMS_RST_LO];
   assign exp_rhd = 6'(r.cfg[`AMS_RHD_HI:`AMS_RHD_LO]);
   assign exp_wst = r.cfg[`AMS_WST_HI:`AMS_WST_LO];
   assign exp_ta = r.cfg[`AMS_TA_HI:`AMS_TA_LO];
   // Widest sum is 85, so six bits would wrap on the slowest setting
   assign exp_sum = 8'(r.cfg[`AMS_WSU_HI:`AMS_WSU_LO]) + 8'(exp_wst)
                    + 8'(r.cfg[`AMS_WHD_HI:`AMS_WHD_LO]);

   // Cycles spent in the current phase, whole access, and since strobe end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_reg <= 8'h00;
         acc_reg <= 8'h00;
         gap_reg <= 8'h00;
      end else begin
         pc_reg <= (n.st != r.st) ? 8'h00 : pc_reg + 8'h01;
         acc_reg <= r.busy ? acc_reg + 8'h01 : 8'h00;
         gap_reg <= (r.st == ams_pkg::AMS_STROBE) ? 8'h00
                    : (gap_reg == 8'hFF ? gap_reg : gap_reg + 8'h01);
      end
   end

   ss_cs_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cfg[`AMS_SS_BIT] && r.busy |-> (mem_cs_n_o == (r.st != ams_pkg::AMS_STROBE)))
      else $error("select strobe does not match strobe phase");

   width_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_data_oe_o && !is16(r.cfg) |-> mem_data_o[15:8] == 8'h00)
      else $error("upper lane driven on narrow bus");

   rd_strobe_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_STROBE && !r.wr && n.st == ams_pkg::AMS_HOLD
      |-> pc_reg == 8'(exp_rst) ##1 r.rdata[7:0] == $past(mem_data_i[7:0]))
      else $error("read strobe length or capture wrong");

   rd_hold_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_HOLD && !r.wr && n.st != ams_pkg::AMS_HOLD
      |-> pc_reg == 8'(exp_rhd) && $stable(mem_addr_o))
      else $error("read hold length wrong");

   rd_turn_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_TURN && n.st == ams_pkg::AMS_IDLE
      |-> gap_reg == 8'(exp_rhd) + 8'(exp_ta) + 8'h01 && !mem_data_oe_o)
      else $error("turnaround shorter than hold plus ta plus two");

   ta_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_TURN |-> pc_reg <= 8'h03)
      else $error("turnaround above three cycles plus one");

   wr_strobe_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_STROBE && r.wr && n.st == ams_pkg::AMS_HOLD
      |-> pc_reg == 8'(exp_wst) && !mem_data_oe_o == 1'b0)
      else $error("write strobe length wrong");

   wr_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.wr && r.st == ams_pkg::AMS_SETUP && n.st == ams_pkg::AMS_STROBE
      |-> gap_reg >= 8'(r.cfg[`AMS_WSU_HI:`AMS_WSU_LO]) + 8'h01)
      else $error("write strobe gap too short");

   wr_total_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.wr && r.busy && !n.busy |-> acc_reg == exp_sum + 8'h02)
      else $error("write access length wrong");

   cfg_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req && !wb_we_i && wb_adr_i == `AMS_OFF_CFG |=> wb_ack_o && wb_dat_o == $past(r.cfg))
      else $error("configuration read mismatch");

   addr_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.busy && $past(r.busy) |-> $stable(mem_addr_o) ##0 !(r.st == ams_pkg::AMS_STROBE
      && $past(r.st) == ams_pkg::AMS_IDLE))
      else $error("address moved or setup skipped");

   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held longer than one cycle");

   ack_reply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   setup_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_SETUP && n.st == ams_pkg::AMS_STROBE
      |-> pc_reg == (r.wr ? 8'(r.cfg[`AMS_WSU_HI:`AMS_WSU_LO])
                          : 8'(r.cfg[`AMS_RSU_HI:`AMS_RSU_LO])))
      else $error("setup phase length wrong");

   wr_hold_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_HOLD && r.wr && n.st == ams_pkg::AMS_IDLE
      |-> pc_reg == 8'(r.cfg[`AMS_WHD_HI:`AMS_WHD_LO]))
      else $error("write hold length wrong");

   ws_cs_span_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cfg[`AMS_SS_BIT] && r.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE,
      ams_pkg::AMS_HOLD} |-> !mem_cs_n_o)
      else $error("select dropped inside an access");

   ss_en_span_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.cfg[`AMS_SS_BIT] && r.st inside {ams_pkg::AMS_SETUP, ams_pkg::AMS_STROBE,
      ams_pkg::AMS_HOLD} |-> mem_we_n_o == !r.wr && mem_oe_n_o == r.wr)
      else $error("enables wrong in select strobe mode");

   rd_no_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.busy && !r.wr |-> !mem_data_oe_o)
      else $error("data bus driven during a read");

   wide_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_STROBE && !r.wr && n.st == ams_pkg::AMS_HOLD && is16(r.cfg)
      |=> r.rdata == $past(mem_data_i))
      else $error("wide read capture wrong");

   cfg_frozen_a: assert property (@(posedge clk_i) disable iff (rst_i)
      r.busy && $past(r.busy) |-> $stable(r.cfg))
      else $error("configuration changed during an access");

   rd_strobe_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !r.cfg[`AMS_SS_BIT] && r.st == ams_pkg::AMS_STROBE
      |-> mem_oe_n_o == r.wr && mem_we_n_o == !r.wr)
      else $error("strobe enable wrong in normal mode");

   rd_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
      r.st == ams_pkg::AMS_TURN ##1 r.st == ams_pkg::AMS_IDLE);
   wr_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
      r.wr && r.st == ams_pkg::AMS_HOLD ##1 r.st == ams_pkg::AMS_IDLE);
   ss_mode_c: cover property (@(posedge clk_i) disable iff (rst_i)
      r.cfg[`AMS_SS_BIT] && r.st == ams_pkg::AMS_STROBE);
   narrow_rd_c: cover property (@(posedge clk_i) disable iff (rst_i)
      !is16(r.cfg) && !r.wr && r.st == ams_pkg::AMS_STROBE);
   long_wr_c: cover property (@(posedge clk_i) disable iff (rst_i)
      r.wr && r.busy && !n.busy && acc_reg > 8'h3F);

endmodule

// ==== ams_mem_model.sv ====
`timescale 1ns/1ps
// ==========
// Behavioural parallel memory, 16 words, asynchronous read
module ams_mem_model (
   input wire logic clk_i,
   input wire logic [22:0] addr_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o
);
   logic [15:0] mem [0:15];
   logic [15:0] last;
   logic drv;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hC3A0 | 16'(i);
      end
      last = 16'h0000;
   end
   // Released bus shows the inverse, so a late capture cannot pass
   assign drv = !cs_n_i && !oe_n_i;
   assign data_o = drv ? mem[addr_i[3:0]] : ~last;
   always @(posedge clk_i) begin
      if (drv) begin
         last <= data_o;
      end
      if (!cs_n_i && !we_n_i) begin
         mem[addr_i[3:0]] <= data_i;
      end
   end
endmodule

// ==== ams_ctrl_tb.sv ====
`timescale 1ns/1ps
module ams_ctrl_tb;
   typedef struct {logic [31:0] cfg; logic wr; int e_cs; int e_stb; logic [15:0] e_dat;} ams_row_t;
   logic clk_i, rst_i, cyc, stb, we, ack, cs_n, we_n, oe_n, doe;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, dat_o, q;
   logic [22:0] maddr;
   logic [15:0] mdo, mdi;
   int n_fail, checks_done, cyc_cnt, n_cs, n_we, n_oe, n_drv;
   // counts chosen to fit the memory
   ams_row_t rows [6] = '{
      '{32'h00100001, 1'b1, 4, 2, 16'h5A30}, '{32'h00000001, 1'b0, 3, 1, 16'hC3A1},
      '{32'h886225BD, 1'b1, 7, 12, 16'h5A32}, '{32'h886225BD, 1'b0, 12, 18, 16'hC3A3},
      '{32'h3FFE0001, 1'b1, 88, 64, 16'h5A34}, '{32'h0001FFFC, 1'b0, 88, 64, 16'h00A5}};
   ams_ctrl i_ams_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .mem_addr_o(maddr), .mem_cs_n_o(cs_n), .mem_we_n_o(we_n),
      .mem_oe_n_o(oe_n), .mem_data_o(mdo), .mem_data_oe_o(doe), .mem_data_i(mdi));
   ams_mem_model i_ams_mem_model (.clk_i(clk_i), .addr_i(maddr), .cs_n_i(cs_n),
      .we_n_i(we_n), .oe_n_i(oe_n), .data_i(mdo), .data_o(mdi));
   // ==========
   // Clock, pin monitor and timeout
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // Counted on the falling edge so clearing at a rising edge never races
   always @(negedge clk_i) begin
      n_cs += int'(!cs_n);
      n_we += int'(!we_n);
      n_oe += int'(!oe_n);
      n_drv += int'(doe);
   end
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 10000) begin
         n_fail++;
         give_verdict();
      end
   end
   // ==========
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic run(input logic w, input logic [15:0] d, input logic [22:0] a);
      wb(1'b1, 8'h04, {9'h000, a});
      wb(1'b1, 8'h08, {16'h0000, d});
      n_cs = 0;
      n_we = 0;
      n_oe = 0;
      n_drv = 0;
      wb(1'b1, 8'h00, {30'h0, w, 1'b1});
      // Only the bench timeout ends a hung access
      do begin
         wb(1'b0, 8'h14, 32'h0);
      end while (q[0] !== 1'b0);
      chk({31'h0, q[1]}, 32'h00000001); // access completes
      wb(1'b1, 8'h14, 32'h00000002);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========
   // Main sequence
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      dat = 32'h0;
      n_fail = 0;
      checks_done = 0;
      cyc_cnt = 0;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wb(1'b1, 8'h10, rows[i].cfg);
         wb(1'b0, 8'h10, 32'h0);
         chk(q, rows[i].cfg); // layout readback
         run(rows[i].wr, rows[i].e_dat, 23'(i));
         chk(n_cs, rows[i].e_cs); // select span
         chk(rows[i].wr ? n_we : n_oe, rows[i].e_stb); // strobe span
         chk(rows[i].wr ? n_oe : n_drv, 0); // no drive on reads
         wb(1'b0, 8'h0C, 32'h0);
         if (rows[i].wr) begin
            chk(i_ams_mem_model.mem[i], rows[i].e_dat); // full word written
         end else begin
            chk(q, {16'h0000, rows[i].e_dat}); // captured width
         end
         $display("row %0d done", i);
      end
      wb(1'b1, 8'h10, 32'h3FFE0001);
      wb(1'b1, 8'h00, 32'h00000003);
      wb(1'b1, 8'h10, 32'h00000001);
      repeat (100) @(posedge clk_i);
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h3FFE0001); // held while busy
      wb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h00000000); // unmapped reads zero
      sel <= 4'h1;
      wb(1'b1, 8'h10, 32'h000000A5);
      sel <= 4'hF;
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h3FFE00A5); // byte lane write
      $display("busy and unmapped test done");
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h3FFFFFFD); // reset value
      chk({31'h0, cs_n}, 32'h00000001); // idle select
      $display("reset test done");
      give_verdict();
   end
endmodule
